// ===== design/bit_sync.sv
`timescale 1ns/100ps
// Two-flop synchroniser; the first stage feeds only the second.
module bit_sync #(
  parameter int WIDTH = 1
) (
  // Destination clock and reset.
  input  wire logic             clock,
  input  wire logic             rst,
  // Foreign levels in, settled levels out.
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage; // First stage, may go metastable.

  // Both stages clear under reset so outputs start low.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stage    <= '0;
      sync_out <= '0;
    end else begin
      stage    <= async_in;
      sync_out <= stage;
    end
  end

endmodule

// ===== design/charger_detect_pkg.sv
package charger_detect_pkg;

  // Six analog enables of the detection block, in bit order msb first.
  typedef struct packed {
    logic data_voltage_source_enable;
    logic data_current_sink_enable;
    logic contact_detect_enable;
    logic host_charger_enable;
    logic plus_line_pulldown;
    logic minus_line_pulldown;
  } charger_enables_t;

  // Enable patterns that name each detection mode.
  localparam logic [5:0] PATTERN_CONNECT_DETECT  = 6'h09;
  localparam logic [5:0] PATTERN_CHARGER_DETECT  = 6'h30;
  localparam logic [5:0] PATTERN_ENHANCED_DETECT = 6'h34;
  localparam logic [5:0] PATTERN_DEVICE_USB      = 6'h00;
  localparam logic [5:0] PATTERN_HOST_IDLE       = 6'h17;
  localparam logic [5:0] PATTERN_HOST_ATTACHED   = 6'h37;
  localparam logic [5:0] PATTERN_HOST_USB        = 6'h07;

  // Audio switch enables; all reset to disabled.
  typedef struct packed {
    logic left_speaker_switch_enable;
    logic right_speaker_switch_enable;
    logic microphone_switch_enable;
  } audio_switches_t;
  localparam logic [2:0] AUDIO_RESET = 3'h0;

  // Status byte sent to the controller when the device owns the bus.
  typedef struct packed {
    logic       alert;
    logic       id;
    logic [1:0] rx_event;
    logic [1:0] vbus_state;
    logic [1:0] line_state;
  } rx_status_t;

  // Command byte from the controller: kind in the top two bits.
  typedef struct packed {
    logic [1:0] kind;
    logic [5:0] payload;
  } link_cmd_t;

  localparam logic [1:0] CMD_TRANSMIT  = 2'h1;
  localparam logic [1:0] CMD_REG_WRITE = 2'h2;
  localparam logic [7:0] BUS_IDLE      = 8'h00;

  localparam logic [1:0] LINE_SE0           = 2'h0;
  localparam logic [1:0] VBUS_SESSION_VALID = 2'h2;
  localparam logic [1:0] VBUS_BELOW_SESSION = 2'h0;

  // Receive end latency in high-speed clocks, and the allowed maximum.
  localparam logic [5:0] RX_END_LATENCY     = 6'h2b;
  localparam logic [5:0] RX_END_LATENCY_MAX = 6'h3f;

  // Decoded detection mode, one-hot.
  typedef enum logic [7:0] {
    MODE_CONNECT_DETECT  = 8'h01,
    MODE_CHARGER_DETECT  = 8'h02,
    MODE_ENHANCED_DETECT = 8'h04,
    MODE_DEVICE_USB      = 8'h08,
    MODE_HOST_IDLE       = 8'h10,
    MODE_HOST_ATTACHED   = 8'h20,
    MODE_HOST_USB        = 8'h40,
    MODE_OTHER           = 8'h80
  } mode_t;

  // Bus protocol states on the link clock, one-hot.
  typedef enum logic [6:0] {
    LINK_IDLE     = 7'h01,
    LINK_TRANSMIT = 7'h02,
    LINK_REG_DATA = 7'h04,
    LINK_REG_STOP = 7'h08,
    LINK_TURN_OUT = 7'h10,
    LINK_STATUS   = 7'h20,
    LINK_TURN_IN  = 7'h40
  } link_state_t;

endpackage

// ===== design/charger_detect_sequencer.sv
`timescale 1ns/100ps
// Operation
// - Data-detect flag asserts only at line levels 00.
// - Weak pull-ups off while chip enable low.
// - Audio switches off in USB or with chip enable low, else follow enables.
// - Line receivers on in synchronous, off carkit.
// - Receive end signalled within 43 clocks.
// - Device owns bus direction via DIR.
// - One decoder routes commands to transmitter/registers.
// - Flag changes reported in both power modes.
module charger_detect_sequencer
  import charger_detect_pkg::*;
(
  // Core clock and reset.
  input  wire logic             clock,
  input  wire logic             rst,
  // Link clock for the bus logic.
  input  wire logic             ulpi_clock,
  // Pins and analog comparators, asynchronous to both clocks.
  input  wire logic             chip_enable_pin,
  input  wire logic             session_valid_in,
  input  wire logic [1:0]       line_state_in,
  input  wire logic             data_compare_in,
  // Configuration from the controller, core clock domain.
  input  wire charger_enables_t charger_enables_in,
  input  wire logic             weak_pullup_plus_enable,
  input  wire logic             weak_pullup_minus_enable,
  input  wire audio_switches_t  audio_enables,
  input  wire logic             sync_mode,
  input  wire logic             carkit_mode,
  input  wire logic             alert_clear,
  input  wire logic             rx_end_seen,
  // Analog controls and status, core clock domain.
  output charger_enables_t      charger_enables,
  output logic                  pullup_plus,
  output logic                  pullup_minus,
  output audio_switches_t       audio_switches,
  output logic                  receivers_enable,
  output logic                  data_detect_flag,
  output mode_t                 detection_mode,
  output logic                  detect_change_alert,
  output logic                  rx_end_signal,
  // Shared eight-bit bus, link clock domain.
  input  wire logic [7:0]       data_in,
  output logic      [7:0]       data_out,
  output logic                  data_oe,
  output logic                  dir,
  output logic                  nxt,
  input  wire logic             stp,
  // Routed traffic, link clock domain.
  output logic      [7:0]       tx_data,
  output logic                  tx_valid,
  output logic      [5:0]       reg_addr,
  output logic      [7:0]       reg_data,
  output logic                  reg_write
);

  // Name an enable pattern as a detection mode.
  function automatic mode_t decode_mode(input charger_enables_t en);
    case (en)
      PATTERN_CONNECT_DETECT:  decode_mode = MODE_CONNECT_DETECT;
      PATTERN_CHARGER_DETECT:  decode_mode = MODE_CHARGER_DETECT;
      PATTERN_ENHANCED_DETECT: decode_mode = MODE_ENHANCED_DETECT;
      PATTERN_DEVICE_USB:      decode_mode = MODE_DEVICE_USB;
      PATTERN_HOST_IDLE:       decode_mode = MODE_HOST_IDLE;
      PATTERN_HOST_ATTACHED:   decode_mode = MODE_HOST_ATTACHED;
      PATTERN_HOST_USB:        decode_mode = MODE_HOST_USB;
      default:                 decode_mode = MODE_OTHER;
    endcase
  endfunction

  // ---------------- Core clock domain ----------------

  logic [4:0] pins_sync;     // Settled pin and comparator levels.
  logic       chip_en;       // Settled chip enable.
  logic       session_valid; // Settled session valid level.
  logic [1:0] line_state;    // Settled line levels.
  logic       data_compare;  // Settled comparator output.
  logic [1:0] line_state_q;  // Line levels held beside the flag.
  logic       flag_prev;     // Flag one cycle back, for change detect.
  logic [5:0] latency_count; // Cycles left before receive end.
  logic       latency_busy;  // A receive end is being timed.

  // Pins are foreign to the core clock, so each passes two flops.
  bit_sync #(.WIDTH(5)) pin_sync (
    .clock    (clock),
    .rst      (rst),
    .async_in ({chip_enable_pin, session_valid_in, line_state_in,
                data_compare_in}),
    .sync_out (pins_sync)
  );
  assign {chip_en, session_valid, line_state, data_compare} = pins_sync;

  // The comparator is qualified by the line levels, so a stray
  // comparator trip on a non-idle line never reaches the flag.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      data_detect_flag <= 1'b0;
      line_state_q     <= LINE_SE0;
    end else begin
      data_detect_flag <= data_compare && (line_state == LINE_SE0);
      line_state_q     <= line_state;
    end
  end

  // The enables pass straight to the analog block; the mode decode
  // only reports which table row the controller has chosen.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      charger_enables <= charger_enables_t'(PATTERN_DEVICE_USB);
      detection_mode  <= MODE_DEVICE_USB;
    end else begin
      charger_enables <= charger_enables_in;
      detection_mode  <= decode_mode(charger_enables_in);
    end
  end

  // Weak pull-ups need the supply that chip enable brings up.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pullup_plus  <= 1'b0;
      pullup_minus <= 1'b0;
    end else begin
      pullup_plus  <= chip_en && weak_pullup_plus_enable;
      pullup_minus <= chip_en && weak_pullup_minus_enable;
    end
  end

  // Switches close only in carkit audio use with the supply present;
  // an external supply alone does not close them.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      audio_switches <= audio_switches_t'(AUDIO_RESET);
    end else if (chip_en && carkit_mode) begin
      audio_switches <= audio_enables;
    end else begin
      audio_switches <= audio_switches_t'(AUDIO_RESET);
    end
  end

  // Single-ended receivers run in synchronous mode only.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      receivers_enable <= 1'b0;
    end else begin
      receivers_enable <= sync_mode && !carkit_mode;
    end
  end

  // Sticky alert for flag changes, readable with the link clock off.
  // A change in the clear cycle wins over the clear.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      flag_prev           <= 1'b0;
      detect_change_alert <= 1'b0;
    end else begin
      flag_prev <= data_detect_flag;
      if (flag_prev != data_detect_flag) begin
        detect_change_alert <= 1'b1;
      end else if (alert_clear) begin
        detect_change_alert <= 1'b0;
      end
    end
  end

  // Receive end timer; a new end while busy is ignored because the
  // bus cannot deliver two packet ends that close together.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      latency_count <= 6'h00;
      latency_busy  <= 1'b0;
      rx_end_signal <= 1'b0;
    end else begin
      rx_end_signal <= 1'b0;
      if (!latency_busy && rx_end_seen) begin
        latency_count <= RX_END_LATENCY - 6'h01;
        latency_busy  <= 1'b1;
      end else if (latency_busy && latency_count == 6'h01) begin
        latency_busy  <= 1'b0;
        rx_end_signal <= 1'b1;
      end else if (latency_busy) begin
        latency_count <= latency_count - 6'h01;
      end
    end
  end

  // ---------------- Link clock domain ----------------

  logic [1:0]  link_rst_pipe;  // Reset release aligned to link clock.
  logic        link_rst;       // Reset for the link domain.
  logic [3:0]  core_sync;      // Core levels seen on the link clock.
  logic        link_flag;      // Flag as seen on the link clock.
  logic        link_flag_prev; // Previous link-side flag.
  logic        link_session;   // Session valid on the link clock.
  logic [1:0]  link_line;      // Line levels on the link clock.
  logic        status_pending; // A status byte awaits the bus.
  link_cmd_t   cmd;            // Bus byte viewed as a command.
  link_state_t state;          // Bus protocol state.
  link_state_t next_state;     // Next bus protocol state.
  rx_status_t  status_byte;    // Status byte to send.

  // Asserts at once, releases two link edges after rst falls.
  always_ff @(posedge ulpi_clock or posedge rst) begin
    if (rst) begin
      link_rst_pipe <= 2'h3;
    end else begin
      link_rst_pipe <= {link_rst_pipe[0], 1'b0};
    end
  end
  assign link_rst = link_rst_pipe[1];

  // Core registers are levels, so two flops carry them across.
  bit_sync #(.WIDTH(4)) core_to_link (
    .clock    (ulpi_clock),
    .rst      (link_rst),
    .async_in ({data_detect_flag, session_valid, line_state_q}),
    .sync_out (core_sync)
  );
  assign {link_flag, link_session, link_line} = core_sync;

  assign cmd = link_cmd_t'(data_in);
  assign status_byte = '{alert:      link_flag,
                         id:         1'b0,
                         rx_event:   2'h0,
                         vbus_state: link_session ? VBUS_SESSION_VALID
                                                  : VBUS_BELOW_SESSION,
                         line_state: link_line};

  // Pending report of a flag change; the send clears it, but a
  // change in the same cycle keeps it set.
  always_ff @(posedge ulpi_clock or posedge link_rst) begin
    if (link_rst) begin
      link_flag_prev <= 1'b0;
      status_pending <= 1'b0;
    end else begin
      link_flag_prev <= link_flag;
      if (link_flag != link_flag_prev) begin
        status_pending <= 1'b1;
      end else if (state == LINK_STATUS) begin
        status_pending <= 1'b0;
      end
    end
  end

  // One decoder for all controller traffic. A command from the
  // controller wins over a pending status, which waits for idle.
  always_comb begin
    next_state = state;
    case (state)
      LINK_IDLE: begin
        if (data_in != BUS_IDLE && cmd.kind == CMD_TRANSMIT) begin
          next_state = LINK_TRANSMIT;
        end else if (data_in != BUS_IDLE && cmd.kind == CMD_REG_WRITE) begin
          next_state = LINK_REG_DATA;
        end else if (data_in == BUS_IDLE && status_pending) begin
          next_state = LINK_TURN_OUT;
        end
      end
      LINK_TRANSMIT: if (stp) next_state = LINK_IDLE;
      LINK_REG_DATA: next_state = stp ? LINK_IDLE : LINK_REG_STOP;
      LINK_REG_STOP: if (stp) next_state = LINK_IDLE;
      LINK_TURN_OUT: next_state = LINK_STATUS;
      LINK_STATUS:   next_state = LINK_TURN_IN;
      LINK_TURN_IN:  next_state = LINK_IDLE;
      default:       next_state = LINK_IDLE;
    endcase
  end

  // State register.
  always_ff @(posedge ulpi_clock or posedge link_rst) begin
    if (link_rst) begin
      state <= LINK_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Bus direction and throttle; no one drives in turnaround cycles.
  assign dir = (state == LINK_TURN_OUT) || (state == LINK_STATUS);
  assign nxt = (state == LINK_IDLE && data_in != BUS_IDLE &&
                (cmd.kind == CMD_TRANSMIT || cmd.kind == CMD_REG_WRITE)) ||
               ((state == LINK_TRANSMIT || state == LINK_REG_DATA) && !stp);
  assign data_oe = (state == LINK_STATUS);

  // Status byte is loaded during turnaround and driven next cycle.
  always_ff @(posedge ulpi_clock or posedge link_rst) begin
    if (link_rst) begin
      data_out <= BUS_IDLE;
    end else if (state == LINK_TURN_OUT) begin
      data_out <= status_byte;
    end
  end

  // Transmit route: command byte with its identifier, then payload.
  always_ff @(posedge ulpi_clock or posedge link_rst) begin
    if (link_rst) begin
      tx_data  <= 8'h00;
      tx_valid <= 1'b0;
    end else begin
      tx_valid <= 1'b0;
      if ((next_state == LINK_TRANSMIT && state == LINK_IDLE) ||
          (state == LINK_TRANSMIT && !stp)) begin
        tx_data  <= data_in;
        tx_valid <= 1'b1;
      end
    end
  end

  // Register route: address from the command, data from next byte.
  always_ff @(posedge ulpi_clock or posedge link_rst) begin
    if (link_rst) begin
      reg_addr  <= 6'h00;
      reg_data  <= 8'h00;
      reg_write <= 1'b0;
    end else begin
      reg_write <= 1'b0;
      if (next_state == LINK_REG_DATA) begin
        reg_addr <= cmd.payload;
      end
      if (state == LINK_REG_DATA && !stp) begin
        reg_data  <= data_in;
        reg_write <= 1'b1;
      end
    end
  end

  // ---------------- Checks ----------------

  sequence rx_end_start;
    !latency_busy && rx_end_seen;
  endsequence
  sequence rx_end_done;
    ##43 rx_end_signal;
  endsequence
  sequence turn_then_drive;
    !data_oe ##1 data_oe ##1 (!dir && !data_oe);
  endsequence

  chk_flag_linestate: assert property (@(posedge clock) disable iff (rst)
    data_detect_flag |-> line_state_q == LINE_SE0)
    else $error("Data detect flag high on a non-idle line.");

  chk_pullup_gate: assert property (@(posedge clock) disable iff (rst)
    !chip_en |=> !pullup_plus && !pullup_minus)
    else $error("Weak pull-up on while chip enable low.");

  chk_pullup_follow: assert property (@(posedge clock) disable iff (rst)
    chip_en && weak_pullup_plus_enable |=> pullup_plus)
    else $error("Weak pull-up did not follow its enable.");

  chk_switch_chip: assert property (@(posedge clock) disable iff (rst)
    !chip_en |=> audio_switches == audio_switches_t'(AUDIO_RESET))
    else $error("Audio switch closed with chip enable low.");

  chk_switch_usb: assert property (@(posedge clock) disable iff (rst)
    !carkit_mode |=> audio_switches == audio_switches_t'(AUDIO_RESET))
    else $error("Audio switch closed outside audio use.");

  chk_receiver_mode: assert property (@(posedge clock) disable iff (rst)
    carkit_mode |=> !receivers_enable)
    else $error("Line receivers left on in carkit mode.");

  chk_rx_end_time: assert property (@(posedge clock) disable iff (rst)
    rx_end_start |-> rx_end_done)
    else $error("Receive end not signalled at its latency.");

  chk_dir_turn: assert property (@(posedge ulpi_clock) disable iff (link_rst)
    $rose(dir) |-> turn_then_drive)
    else $error("Bus driven without a turnaround cycle.");

  chk_cmd_route: assert property (@(posedge ulpi_clock) disable iff (link_rst)
    state == LINK_IDLE && data_in != BUS_IDLE && cmd.kind == CMD_REG_WRITE
    |=> state == LINK_REG_DATA)
    else $error("Register write command not routed.");

  chk_status_send: assert property (@(posedge ulpi_clock) disable iff (link_rst)
    state == LINK_IDLE && data_in == BUS_IDLE && status_pending
    |=> dir ##1 data_oe && data_out[7] == $past(link_flag))
    else $error("Flag change not reported on the bus.");

endmodule

// ===== tb/link_model.sv
`timescale 1ns/100ps
// Link controller model on the shared bus.
module link_model
  import charger_detect_pkg::*;
(
  // Link clock and bus control from the device.
  input  wire logic       ulpi_clock,
  input  wire logic       dir,
  input  wire logic       nxt,
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe,
  // Bus level seen by the device, and the stop line.
  output logic      [7:0] data_in,
  output logic            stp
);
  logic [7:0] link_data;   // Byte the link drives while it owns the bus.
  logic [7:0] status_byte; // Last status byte taken from the device.
  logic       sess_seen;   // Session valid has been reported.

  initial begin
    link_data   = BUS_IDLE;
    stp         = 1'b0;
    status_byte = 8'h00;
    sess_seen   = 1'b0;
  end

  // Undriven turnaround shows scrambled data, not the last byte.
  assign data_in = data_oe ? data_out : (dir ? ~link_data : link_data);

  // Take each status byte.
  always @(posedge ulpi_clock) begin
    if (dir && data_oe) begin
      status_byte <= data_out;
      sess_seen   <= sess_seen | (data_out[3:2] == VBUS_SESSION_VALID);
    end
  end

  // Wait until the device leaves the bus.
  task automatic take_bus;
    int n;
    n = 0;
    @(posedge ulpi_clock);
    #1;
    while (dir !== 1'b0 && n < 40) begin
      @(posedge ulpi_clock);
      #1;
      n++;
    end
  endtask

  // Hold one byte until nxt accepts it.
  task automatic put_byte(input logic [7:0] b);
    int n;
    n = 0;
    link_data = b;
    #1;
    while (nxt !== 1'b1 && n < 40) begin
      @(posedge ulpi_clock);
      #1;
      n++;
    end
    @(posedge ulpi_clock);
    #1;
  endtask

  // One-cycle stop, idle bus.
  task automatic finish_frame;
    link_data = BUS_IDLE;
    stp = 1'b1;
    @(posedge ulpi_clock);
    #1;
    stp = 1'b0;
  endtask

  // Register write: command, then data.
  task automatic send_reg(input logic [5:0] a, input logic [7:0] d);
    take_bus();
    put_byte({CMD_REG_WRITE, a});
    put_byte(d);
    finish_frame();
  endtask

  // Transmit: command, one byte, stop.
  task automatic send_tx(input logic [7:0] c, input logic [7:0] b);
    take_bus();
    put_byte(c);
    link_data = b;
    @(posedge ulpi_clock);
    #1;
    finish_frame();
  endtask
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/100ps
// Self-checking bench: core controls, detection flows and bus traffic.
module tb_top
  import charger_detect_pkg::*;
;
  localparam int CONTACT_TIMEOUT = 20; // Contact-detect wait, core cycles.
  logic             clock, rst, ulpi_clock, chip_enable_pin;
  logic             session_valid_in, data_compare_in, sync_mode;
  logic             weak_pullup_plus_enable, weak_pullup_minus_enable;
  logic             carkit_mode, alert_clear, rx_end_seen, pullup_plus;
  logic             pullup_minus, receivers_enable, data_detect_flag;
  logic             detect_change_alert, rx_end_signal, data_oe, dir, nxt;
  logic             stp, tx_valid, reg_write;
  logic [1:0]       line_state_in;
  logic [5:0]       reg_addr;
  logic [7:0]       data_in, data_out, tx_data, reg_data;
  logic [7:0]       tx_cnt, wr_cnt, wr_addr, wr_data;
  logic [15:0]      tx_log;
  charger_enables_t charger_enables_in, charger_enables;
  audio_switches_t  audio_enables, audio_switches;
  mode_t            detection_mode;
  int               num_errors = 0;
  int               n_compared = 0;

  charger_detect_sequencer u_charger_detect_sequencer (
    .clock(clock), .rst(rst), .ulpi_clock(ulpi_clock),
    .chip_enable_pin(chip_enable_pin), .session_valid_in(session_valid_in),
    .line_state_in(line_state_in), .data_compare_in(data_compare_in),
    .charger_enables_in(charger_enables_in),
    .weak_pullup_plus_enable(weak_pullup_plus_enable),
    .weak_pullup_minus_enable(weak_pullup_minus_enable),
    .audio_enables(audio_enables), .sync_mode(sync_mode),
    .carkit_mode(carkit_mode), .alert_clear(alert_clear),
    .rx_end_seen(rx_end_seen), .charger_enables(charger_enables),
    .pullup_plus(pullup_plus), .pullup_minus(pullup_minus),
    .audio_switches(audio_switches), .receivers_enable(receivers_enable),
    .data_detect_flag(data_detect_flag), .detection_mode(detection_mode),
    .detect_change_alert(detect_change_alert),
    .rx_end_signal(rx_end_signal), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .dir(dir), .nxt(nxt), .stp(stp), .tx_data(tx_data),
    .tx_valid(tx_valid), .reg_addr(reg_addr), .reg_data(reg_data),
    .reg_write(reg_write));

  link_model u_link_model (
    .ulpi_clock(ulpi_clock), .dir(dir), .nxt(nxt), .data_out(data_out),
    .data_oe(data_oe), .data_in(data_in), .stp(stp));

  // Core clock.
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Link clock, 125 ns, phase offset from the core.
  initial begin
    ulpi_clock = 1'b0;
    #37;
    forever #62.5 ulpi_clock = ~ulpi_clock;
  end

  // Record routed traffic.
  always @(posedge ulpi_clock) begin
    if (tx_valid === 1'b1) begin
      tx_log <= {tx_log[7:0], tx_data};
      tx_cnt <= tx_cnt + 8'h01;
    end
    if (reg_write === 1'b1) begin
      wr_addr <= {2'h0, reg_addr};
      wr_data <= reg_data;
      wr_cnt  <= wr_cnt + 8'h01;
    end
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Enables settle within three edges.
  task automatic set_en(input logic [5:0] p);
    charger_enables_in = p;
    tick(3);
  endtask

  // One detection flow. Class: 0 unknown, 1 standard,
  // 2 charging downstream, 3 dedicated.
  task automatic flow_case(input logic [1:0] ls, input logic c1, c2,
                           input logic [7:0] expk, expm);
    logic [7:0] kind;
    kind = 8'hff;
    if (u_link_model.sess_seen === 1'b1) begin
      set_en(PATTERN_CONNECT_DETECT);
      line_state_in = ls;
      data_compare_in = 1'b0;
      tick(CONTACT_TIMEOUT);
      if (ls == 2'h2) begin
        kind = 8'h00;
      end else begin
        line_state_in = LINE_SE0;
        data_compare_in = c1;
        set_en(PATTERN_CHARGER_DETECT);
        tick(4);
        if (data_detect_flag === 1'b0) begin
          kind = 8'h01;
          set_en(PATTERN_DEVICE_USB);
        end else begin
          data_compare_in = c2;
          set_en(PATTERN_ENHANCED_DETECT);
          tick(4);
          if (data_detect_flag === 1'b0) begin
            kind = 8'h02;
            set_en(PATTERN_DEVICE_USB);
          end else begin
            kind = 8'h03;
          end
        end
      end
    end
    check("port class", expk, kind);
    check("final mode", expm, detection_mode);
  endtask

  task automatic results;
    if (num_errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // A hang is cut at 300 us.
  initial begin
    #300000;
    num_errors++;
    results();
  end

  initial begin
    logic [5:0] pats [7];
    int         n;
    pats = '{PATTERN_CONNECT_DETECT, PATTERN_CHARGER_DETECT,
             PATTERN_ENHANCED_DETECT, PATTERN_DEVICE_USB, PATTERN_HOST_IDLE,
             PATTERN_HOST_ATTACHED, PATTERN_HOST_USB};
    rst = 1'b1;
    {chip_enable_pin, session_valid_in, line_state_in, data_compare_in,
     charger_enables_in, weak_pullup_plus_enable, weak_pullup_minus_enable,
     audio_enables, sync_mode, carkit_mode, alert_clear, rx_end_seen} = 20'h0;
    {tx_log, tx_cnt, wr_addr, wr_data, wr_cnt} = 48'h0;
    // Held long enough for two link edges.
    tick(30);
    rst = 1'b0;
    tick(3);
    check("audio reset", 8'h00, 8'(audio_switches));
    check("mode reset", MODE_DEVICE_USB, detection_mode);
    // Weak pull-ups gated by the chip enable pin.
    {weak_pullup_plus_enable, weak_pullup_minus_enable} = 2'h3;
    tick(5);
    check("pullups off", 8'h00, {6'h0, pullup_plus, pullup_minus});
    {chip_enable_pin, weak_pullup_minus_enable} = 2'h2;
    tick(5);
    check("pullups 10", 8'h02, {6'h0, pullup_plus, pullup_minus});
    {weak_pullup_plus_enable, weak_pullup_minus_enable} = 2'h1;
    tick(5);
    check("pullups 01", 8'h01, {6'h0, pullup_plus, pullup_minus});
    // Audio switches and line receivers across modes and the pin.
    {audio_enables, sync_mode} = 4'hb;
    tick(3);
    check("audio usb", 8'h00, 8'(audio_switches));
    check("receivers on", 8'h01, {7'h0, receivers_enable});
    carkit_mode = 1'b1;
    tick(3);
    check("audio carkit", 8'h05, 8'(audio_switches));
    check("receivers off", 8'h00, {7'h0, receivers_enable});
    chip_enable_pin = 1'b0;
    tick(5);
    check("audio pin low", 8'h00, 8'(audio_switches));
    {chip_enable_pin, carkit_mode} = 2'h2;
    // Every mode pattern and one outside the table.
    for (int i = 0; i < 7; i++) begin
      set_en(pats[i]);
      check("enables", {2'h0, pats[i]}, 8'(charger_enables));
      check("mode", 8'h01 << i, detection_mode);
    end
    set_en(6'h3f);
    check("mode other", MODE_OTHER, detection_mode);
    // Flag gated by line levels; alert and status.
    session_valid_in = 1'b1;
    tick(5);
    alert_clear = 1'b1;
    tick(1);
    alert_clear = 1'b0;
    data_compare_in = 1'b1;
    tick(5);
    check("flag at 00", 8'h01, {7'h0, data_detect_flag});
    check("alert", 8'h01, {7'h0, detect_change_alert});
    for (n = 0; n < 300 && u_link_model.sess_seen !== 1'b1; n++) tick(1);
    check("status", 8'h88, u_link_model.status_byte);
    alert_clear = 1'b1;
    tick(1);
    alert_clear = 1'b0;
    tick(1);
    check("alert clear", 8'h00, {7'h0, detect_change_alert});
    line_state_in = 2'h1;
    tick(5);
    check("flag at 01", 8'h00, {7'h0, data_detect_flag});
    // Receive end timing.
    rx_end_seen = 1'b1;
    tick(1);
    rx_end_seen = 1'b0;
    for (n = 1; n < 100 && rx_end_signal !== 1'b1; n++) tick(1);
    check("rx end delay", {2'h0, RX_END_LATENCY}, 8'(n));
    tick(1);
    check("rx end pulse", 8'h00, {7'h0, rx_end_signal});
    // Bus traffic routed to registers and transmitter.
    u_link_model.send_reg(6'h15, 8'h5a);
    u_link_model.send_tx(8'h41, 8'ha5);
    repeat (4) @(posedge ulpi_clock);
    tick(1);
    check("reg writes", 8'h01, wr_cnt);
    check("reg addr", 8'h15, wr_addr);
    check("reg data", 8'h5a, wr_data);
    check("tx count", 8'h02, tx_cnt);
    check("tx cmd", 8'h41, tx_log[15:8]);
    check("tx byte", 8'ha5, tx_log[7:0]);
    // Four detection outcomes.
    flow_case(2'h2, 1'b0, 1'b0, 8'h00, MODE_CONNECT_DETECT);
    flow_case(2'h3, 1'b0, 1'b0, 8'h01, MODE_DEVICE_USB);
    flow_case(2'h0, 1'b1, 1'b0, 8'h02, MODE_DEVICE_USB);
    flow_case(2'h0, 1'b1, 1'b1, 8'h03, MODE_ENHANCED_DETECT);
    results();
  end
endmodule
